//--- src/cmb_defines.svh
// register map, field positions, reset values and limits of the can mailbox block
`ifndef CMB_DEFINES_SVH
`define CMB_DEFINES_SVH

`define CMB_CTRL_OFS 8'h00
`define CMB_BIT_CONFIG_REG1_OFS 8'h04
`define CMB_IFR_OFS 8'h08
`define CMB_ERR_OFS 8'h0C
`define CMB_MASK_OFS 8'h10
`define CMB_TXREQ_OFS 8'h14
`define CMB_MB_BASE 8'h40
`define CMB_MB_LAST 8'h9F
`define CMB_MB_ID_SUB 2'h0
`define CMB_MB_DLO_SUB 2'h1
`define CMB_MB_DHI_SUB 2'h2

`define CMB_AME_BIT 13
`define CMB_AAM_BIT 14
`define CMB_SBG_BIT 10
`define CMB_ID_MSB 10
`define CMB_IFR_PASSIVE 6
`define CMB_IFR_BUSOFF 7
`define CMB_IFR_RXLOST 8
`define CMB_ERR_REC_LSB 16
`define CMB_ERR_ST_LSB 28

`define CMB_CTRL_RST 32'h0000_0000
`define CMB_BIT_CONFIG_REG1_RST 32'h0000_0000
`define CMB_MASK_RST 32'h0000_0000
`define CMB_PASSIVE_LIM 9'h080
`define CMB_BUSOFF_LIM 9'h100
`define CMB_TEC_STEP 9'h008
`define CMB_ID_FIELD 32'h0000_07FF
`define CMB_MODE_FIELD 32'h0000_6000

`endif

//--- src/cmb_pkg.sv
// types shared by the can mailbox block
package cmb_pkg;
    typedef enum logic [1:0] {
        ERR_ACTIVE,
        ERR_PASSIVE,
        ERR_BUS_OFF
    } cmb_err_state_t;

    typedef logic [1:0] cmb_resp_t;
    localparam cmb_resp_t RESP_OKAY = 2'h0;
    localparam cmb_resp_t RESP_DECERR = 2'h3;
endpackage

//--- src/cmb_top.sv
// can mailbox, flag and error-state block with axi4-lite registers and rx fifo
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "cmb_defines.svh"

module cmb_fifo #(
    parameter int WIDTH = 76,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clock) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module cmb_top #(
    parameter int NUM_MB = 6,
    parameter int FIFO_DEPTH = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // axi4-lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    // axi4-lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    // axi4-lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // received frames from the bit engine
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic rx_remote,
    input wire logic [10:0] rx_id,
    input wire logic [63:0] rx_data,
    // frames to the bit engine
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [10:0] tx_id,
    output logic [63:0] tx_data,
    // error events from the bit engine
    input wire logic err_tx_pulse,
    input wire logic err_rx_pulse,
    input wire logic own_flag_seen,
    // status and configuration outputs
    output logic sync_both_edges,
    output logic bus_off,
    output logic error_passive,
    output logic core_int_line
);
    localparam int FW = 76;
    localparam int MBW = (NUM_MB > 1) ? $clog2(NUM_MB) : 1;

    // register state
    logic [31:0] ctrl_reg;
    logic [31:0] bit_config_reg1_reg;
    logic [31:0] mask_reg;
    logic [8:0] ifr_reg;
    logic [NUM_MB-1:0] txreq_reg;
    logic [31:0] mb_id_reg [NUM_MB];
    logic [31:0] mb_dlo_reg [NUM_MB];
    logic [31:0] mb_dhi_reg [NUM_MB];
    logic [8:0] tec_reg;
    logic [8:0] rec_reg;
    cmb_pkg::cmb_err_state_t err_state_reg;
    cmb_pkg::cmb_err_state_t err_state_next;
    logic core_int_reg;

    // bus slave state
    logic aw_full_reg;
    logic w_full_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // transmit state
    logic tx_valid_reg;
    logic [10:0] tx_id_reg;
    logic [63:0] tx_data_reg;
    logic [MBW-1:0] tx_sel_reg;

    // internal nets
    logic wr_do;
    logic [31:0] wr_mask;
    logic wr_mb;
    logic [MBW-1:0] wr_idx;
    logic [MBW-1:0] rd_idx;
    logic [31:0] rd_word;
    logic rd_ok;
    logic q_valid;
    logic q_ready;
    logic [FW-1:0] q_data;
    logic q_remote;
    logic [10:0] q_id;
    logic rx_fire;
    logic hit_found;
    logic [MBW-1:0] hit_idx;
    logic [8:0] ifr_set;
    logic [NUM_MB-1:0] auto_set;
    logic tx_fire;
    logic pick_found;
    logic [MBW-1:0] pick_idx;

    assign s_axi_awready = !aw_full_reg;
    assign s_axi_wready = !w_full_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign tx_valid = tx_valid_reg;
    assign tx_id = tx_id_reg;
    assign tx_data = tx_data_reg;
    assign sync_both_edges = bit_config_reg1_reg[`CMB_SBG_BIT];
    assign bus_off = (err_state_reg == cmb_pkg::ERR_BUS_OFF);
    assign error_passive = (err_state_reg == cmb_pkg::ERR_PASSIVE);
    assign core_int_line = core_int_reg;

    assign wr_do = aw_full_reg && w_full_reg && !bvalid_reg;
    assign wr_mask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    assign wr_mb = (aw_addr_reg >= `CMB_MB_BASE) && (aw_addr_reg <= `CMB_MB_LAST)
        && (aw_addr_reg[3:2] != 2'h3);
    assign wr_idx = MBW'((aw_addr_reg - `CMB_MB_BASE) >> 4);
    assign rd_idx = MBW'((s_axi_araddr - `CMB_MB_BASE) >> 4);

    // write channel capture, either order
    always_ff @(posedge clock) begin
        if (reset) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= cmb_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_full_reg) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_full_reg) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_do) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= (wr_mb || aw_addr_reg <= `CMB_TXREQ_OFS) && (aw_addr_reg[1:0] == 2'h0)
                    ? cmb_pkg::RESP_OKAY : cmb_pkg::RESP_DECERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // read decode
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        if (s_axi_araddr[1:0] != 2'h0) begin
            rd_ok = 1'b0;
        end else if (s_axi_araddr >= `CMB_MB_BASE && s_axi_araddr <= `CMB_MB_LAST) begin
            case (s_axi_araddr[3:2])
                `CMB_MB_ID_SUB: rd_word = mb_id_reg[rd_idx];
                `CMB_MB_DLO_SUB: rd_word = mb_dlo_reg[rd_idx];
                `CMB_MB_DHI_SUB: rd_word = mb_dhi_reg[rd_idx];
                default: rd_ok = 1'b0;
            endcase
        end else begin
            case (s_axi_araddr)
                `CMB_CTRL_OFS: rd_word = ctrl_reg;
                `CMB_BIT_CONFIG_REG1_OFS: rd_word = bit_config_reg1_reg;
                `CMB_IFR_OFS: rd_word = {23'h00_0000, ifr_reg};
                `CMB_ERR_OFS: rd_word = {2'h0, err_state_reg, 3'h0, rec_reg, 7'h00, tec_reg};
                `CMB_MASK_OFS: rd_word = mask_reg;
                `CMB_TXREQ_OFS: rd_word = 32'(txreq_reg);
                default: rd_ok = 1'b0;
            endcase
        end
    end

    // read channel
    always_ff @(posedge clock) begin
        if (reset) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= cmb_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_ok ? rd_word : 32'h0000_0000;
            rresp_reg <= rd_ok ? cmb_pkg::RESP_OKAY : cmb_pkg::RESP_DECERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // configuration registers
    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_reg <= `CMB_CTRL_RST;
            bit_config_reg1_reg <= `CMB_BIT_CONFIG_REG1_RST;
            mask_reg <= `CMB_MASK_RST;
        end else if (wr_do) begin
            case (aw_addr_reg)
                // per-mailbox direction
                // direction select
                `CMB_CTRL_OFS: ctrl_reg <= (ctrl_reg & ~wr_mask) | (w_data_reg & wr_mask);
                `CMB_BIT_CONFIG_REG1_OFS: bit_config_reg1_reg <= (bit_config_reg1_reg & ~wr_mask) | (w_data_reg & wr_mask);
                `CMB_MASK_OFS: mask_reg <= (mask_reg & ~wr_mask) | (w_data_reg & wr_mask);
                default: ;
            endcase
        end
    end

    cmb_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) i_cmb_fifo (
        .clock(clock),
        .reset(reset),
        .in_valid(rx_valid),
        .in_ready(rx_ready),
        .in_data({rx_remote, rx_id, rx_data}),
        .out_valid(q_valid),
        .out_ready(q_ready),
        .out_data(q_data)
    );

    assign q_remote = q_data[FW-1];
    assign q_id = q_data[FW-2:64];
    // cpu mailbox write stalls the store
    assign q_ready = !(wr_do && wr_mb);
    assign rx_fire = q_valid && q_ready;

    // acceptance search, lowest mailbox wins
    always_comb begin
        hit_found = 1'b0;
        hit_idx = '0;
        auto_set = '0;
        for (int i = NUM_MB - 1; i >= 0; i--) begin
            if (((q_id ^ mb_id_reg[i][`CMB_ID_MSB:0]) & ~mask_reg[`CMB_ID_MSB:0]) == 11'h000) begin
                if (!ctrl_reg[i] && !q_remote && mb_id_reg[i][`CMB_AME_BIT]) begin
                    hit_found = 1'b1;
                    hit_idx = MBW'(i);
                end
                if (ctrl_reg[i] && q_remote && mb_id_reg[i][`CMB_AAM_BIT] && rx_fire) begin
                    auto_set[i] = 1'b1;
                end
            end
        end
    end

    // mailbox ram
    always_ff @(posedge clock) begin
        if (reset) begin
            for (int i = 0; i < NUM_MB; i++) begin
                mb_id_reg[i] <= 32'h0000_0000;
                mb_dlo_reg[i] <= 32'h0000_0000;
                mb_dhi_reg[i] <= 32'h0000_0000;
            end
        end else if (wr_do && wr_mb) begin
            case (aw_addr_reg[3:2])
                `CMB_MB_ID_SUB: mb_id_reg[wr_idx] <= (mb_id_reg[wr_idx] & ~wr_mask)
                    | (w_data_reg & wr_mask);
                `CMB_MB_DLO_SUB: mb_dlo_reg[wr_idx] <= (mb_dlo_reg[wr_idx] & ~wr_mask)
                    | (w_data_reg & wr_mask);
                `CMB_MB_DHI_SUB: mb_dhi_reg[wr_idx] <= (mb_dhi_reg[wr_idx] & ~wr_mask)
                    | (w_data_reg & wr_mask);
                default: ;
            endcase
        end else if (rx_fire && hit_found) begin
            mb_id_reg[hit_idx] <= (mb_id_reg[hit_idx] & ~`CMB_ID_FIELD) | 32'(q_id);
            mb_dlo_reg[hit_idx] <= q_data[31:0];
            mb_dhi_reg[hit_idx] <= q_data[63:32];
        end
    end

    // pick lowest pending transmit mailbox
    always_comb begin
        pick_found = 1'b0;
        pick_idx = '0;
        for (int i = NUM_MB - 1; i >= 0; i--) begin
            if (txreq_reg[i] && ctrl_reg[i]) begin
                pick_found = 1'b1;
                pick_idx = MBW'(i);
            end
        end
    end

    assign tx_fire = tx_valid_reg && tx_ready;

    // transmit requests, set wins over clear
    always_ff @(posedge clock) begin
        if (reset) begin
            txreq_reg <= '0;
        end else begin
            txreq_reg <= (txreq_reg & ~(tx_fire ? NUM_MB'(1) << tx_sel_reg : '0)) | auto_set
                | ((wr_do && aw_addr_reg == `CMB_TXREQ_OFS) ? w_data_reg[NUM_MB-1:0] : '0);
        end
    end

    // transmit frame holding
    always_ff @(posedge clock) begin
        if (reset) begin
            tx_valid_reg <= 1'b0;
            tx_id_reg <= 11'h000;
            tx_data_reg <= 64'h0000_0000_0000_0000;
            tx_sel_reg <= '0;
        end else if (tx_fire) begin
            tx_valid_reg <= 1'b0;
        end else if (!tx_valid_reg && pick_found && err_state_reg != cmb_pkg::ERR_BUS_OFF) begin
            tx_valid_reg <= 1'b1;
            tx_sel_reg <= pick_idx;
            tx_id_reg <= mb_id_reg[pick_idx][`CMB_ID_MSB:0];
            tx_data_reg <= {mb_dhi_reg[pick_idx], mb_dlo_reg[pick_idx]};
        end
    end

    // error counters
    always_ff @(posedge clock) begin
        if (reset || (wr_do && aw_addr_reg == `CMB_ERR_OFS)) begin
            tec_reg <= 9'h000;
            rec_reg <= 9'h000;
        end else begin
            if (err_tx_pulse) begin
                tec_reg <= (tec_reg >= `CMB_BUSOFF_LIM) ? `CMB_BUSOFF_LIM : tec_reg + `CMB_TEC_STEP;
            end else if (tx_fire && tec_reg != 9'h000) begin
                tec_reg <= tec_reg - 9'h001;
            end
            if (err_rx_pulse) begin
                rec_reg <= (rec_reg >= `CMB_BUSOFF_LIM) ? rec_reg : rec_reg + 9'h001;
            end else if (rx_fire && hit_found && rec_reg != 9'h000) begin
                rec_reg <= rec_reg - 9'h001;
            end
        end
    end

    // error state from counters only
    always_comb begin
        err_state_next = err_state_reg;
        case (err_state_reg)
            cmb_pkg::ERR_ACTIVE: begin
                if (tec_reg >= `CMB_PASSIVE_LIM || rec_reg >= `CMB_PASSIVE_LIM) begin
                    err_state_next = cmb_pkg::ERR_PASSIVE;
                end
            end
            cmb_pkg::ERR_PASSIVE: begin
                if (tec_reg >= `CMB_BUSOFF_LIM) begin
                    err_state_next = cmb_pkg::ERR_BUS_OFF;
                end else if (tec_reg < `CMB_PASSIVE_LIM && rec_reg < `CMB_PASSIVE_LIM) begin
                    err_state_next = cmb_pkg::ERR_ACTIVE;
                end
            end
            cmb_pkg::ERR_BUS_OFF: begin
                if (tec_reg < `CMB_BUSOFF_LIM) begin
                    err_state_next = cmb_pkg::ERR_ACTIVE;
                end
            end
            default: err_state_next = cmb_pkg::ERR_ACTIVE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            err_state_reg <= cmb_pkg::ERR_ACTIVE;
        end else begin
            err_state_reg <= err_state_next;
        end
    end

    // event flags
    always_comb begin
        ifr_set = 9'h000;
        if (rx_fire && hit_found) begin
            ifr_set = ifr_set | (9'h001 << hit_idx);
        end
        if (rx_fire && !hit_found && auto_set == '0) begin
            ifr_set[`CMB_IFR_RXLOST] = 1'b1;
        end
        if (tx_fire) begin
            ifr_set = ifr_set | (9'h001 << tx_sel_reg);
        end
        if (err_state_next == cmb_pkg::ERR_PASSIVE && err_state_reg == cmb_pkg::ERR_ACTIVE) begin
            ifr_set[`CMB_IFR_PASSIVE] = 1'b1;
        end
        if (err_state_next == cmb_pkg::ERR_BUS_OFF && err_state_reg != cmb_pkg::ERR_BUS_OFF) begin
            ifr_set[`CMB_IFR_BUSOFF] = 1'b1;
        end
    end

    // write one to clear, set wins
    always_ff @(posedge clock) begin
        if (reset) begin
            ifr_reg <= 9'h000;
        end else begin
            ifr_reg <= (ifr_reg & ~((wr_do && aw_addr_reg == `CMB_IFR_OFS) ? w_data_reg[8:0] : 9'h000))
                | ifr_set;
        end
    end

    // core interrupt pulse
    always_ff @(posedge clock) begin
        if (reset) begin
            core_int_reg <= 1'b0;
        end else begin
            core_int_reg <= (ifr_set != 9'h000) && (ifr_reg == 9'h000);
        end
    end

    logic unused_ok;
    assign unused_ok = own_flag_seen;
endmodule

//--- verif/cmb_chk.sv
// port checker for the can mailbox block
`timescale 1ns/1ps
module cmb_chk (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // register bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // frames and events
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [10:0] tx_id,
    input wire logic [63:0] tx_data,
    input wire logic err_tx_pulse,
    input wire logic err_rx_pulse,
    // status
    input wire logic bus_off,
    input wire logic error_passive,
    input wire logic core_int_line
);
    logic [3:0] quiet_cnt;
    logic ev;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    assign ev = (rx_valid && rx_ready) || (tx_valid && tx_ready) || err_tx_pulse || err_rx_pulse;
    // cycles since the last flag-raising event
    always_ff @(posedge clock) begin
        if (reset || ev) begin
            quiet_cnt <= 4'h0;
        end else if (quiet_cnt != 4'hF) begin
            quiet_cnt <= quiet_cnt + 4'h1;
        end
    end
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_wr_answer: assert property (s_wr_take |-> ##[1:3] s_axi_bvalid)
        else $error("write not answered");
    a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answered twice");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered");
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable({tx_id, tx_data}))
        else $error("frame dropped early");
    a_int_pulse: assert property (core_int_line |=> !core_int_line)
        else $error("core interrupt too long");
    a_int_cause: assert property (core_int_line |-> quiet_cnt <= 4'h8)
        else $error("core interrupt without event");
    a_state_excl: assert property (!(bus_off && error_passive))
        else $error("two error states");
    a_reset_ready: assert property ($fell(reset) |-> s_axi_awready && s_axi_arready && rx_ready
        && !tx_valid && !core_int_line)
        else $error("not idle after reset");
endmodule
bind cmb_top cmb_chk i_cmb_chk (.*);

//--- verif/cmb_node.sv
// far-side can node model: frame source and sink, error events
`timescale 1ns/1ps
module cmb_node (
    // clock
    input wire logic clock,
    // frames into the block
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_remote,
    output logic [10:0] rx_id,
    output logic [63:0] rx_data,
    // frames out of the block
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [10:0] tx_id,
    input wire logic [63:0] tx_data,
    // error events
    output logic err_tx_pulse,
    output logic err_rx_pulse,
    output logic own_flag_seen
);
    int slow = 0;
    int tx_cnt = 0;
    int wait_cnt = 0;
    int stalls = 0;
    logic [10:0] got_id;
    logic [63:0] got_data;
    initial begin
        {rx_valid, rx_remote, rx_id, rx_data, tx_ready, err_tx_pulse, err_rx_pulse} = '0;
        own_flag_seen = 1'b0;
    end
    always @(posedge clock) begin
        if (tx_valid && tx_ready) begin
            got_id <= tx_id;
            got_data <= tx_data;
            tx_cnt <= tx_cnt + 1;
        end
        tx_ready <= tx_valid && !tx_ready && wait_cnt >= slow;
        wait_cnt <= (tx_valid && !tx_ready) ? wait_cnt + 1 : 0;
    end
    task automatic send(input logic r, input logic [10:0] i, input logic [63:0] d);
        int n;
        n = 0;
        @(posedge clock);
        rx_valid <= 1'b1;
        {rx_remote, rx_id, rx_data} <= {r, i, d};
        do begin
            @(posedge clock);
            n++;
        end while (rx_ready !== 1'b1 && n < 50);
        if (rx_ready !== 1'b1) stalls++;
        rx_valid <= 1'b0;
        {rx_remote, rx_id, rx_data} <= ~{r, i, d};
        @(posedge clock);
    endtask
    task automatic errs(input logic rx, input int n);
        repeat (n) begin
            @(posedge clock);
            {err_tx_pulse, err_rx_pulse} <= {!rx, rx};
            @(posedge clock);
            {err_tx_pulse, err_rx_pulse} <= 2'h0;
        end
    endtask
endmodule

//--- verif/cmb_top_bench.sv
// self-checking bench for the can mailbox block
`timescale 1ns/1ps
module cmb_top_bench;
    logic clock, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic rx_valid, rx_ready, rx_remote, tx_valid, tx_ready, err_tx_pulse, err_rx_pulse;
    logic [10:0] rx_id, tx_id;
    logic [63:0] rx_data, tx_data;
    logic own_flag_seen, sync_both_edges, bus_off, error_passive, core_int_line;
    int fails = 0;
    int cmp_count = 0;
    int pulses = 0;
    cmb_top i_cmb_top (.*);
    cmb_node i_cmb_node (.*);
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) if (core_int_line === 1'b1) pulses <= pulses + 1;
    task automatic chk(input string w, input logic [31:0] got, input logic [31:0] e);
        cmp_count++;
        if (got !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", w, e, got);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input cmb_pkg::cmb_resp_t e = cmb_pkg::RESP_OKAY);
        int n;
        n = 0;
        @(posedge clock);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clock);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 40);
        s_axi_bready <= 1'b0;
        chk("bvalid", {31'h0, s_axi_bvalid}, 32'h1);
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, e});
        if (s_axi_bvalid !== 1'b1) end_of_test();
    endtask
    task automatic rd_chk(input string w, input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m = 32'hFFFF_FFFF, input cmb_pkg::cmb_resp_t r = cmb_pkg::RESP_OKAY);
        int n;
        n = 0;
        @(posedge clock);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge clock);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 40);
        s_axi_rready <= 1'b0;
        chk("rvalid", {31'h0, s_axi_rvalid}, 32'h1);
        chk(w, s_axi_rdata & m, e);
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, r});
        if (s_axi_rvalid !== 1'b1) end_of_test();
    endtask
    initial begin
        reset = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        rd_chk("ctrl", 8'h00, 32'h0);
        rd_chk("flags", 8'h08, 32'h0);
        rd_chk("err", 8'h0C, 32'h0);
        rd_chk("hole", 8'h4C, 32'h0, 32'hFFFF_FFFF, cmb_pkg::RESP_DECERR);
        wr(8'h4C, 32'hFFFF_FFFF, cmb_pkg::RESP_DECERR);
        wr(8'h04, 32'h400);
        chk("sync", {31'h0, sync_both_edges}, 32'h1);
        wr(8'h04, 32'h0);
        $display("test registers done");
        wr(8'h00, 32'h38);
        wr(8'h40, 32'h6123);
        wr(8'h50, 32'h55);
        wr(8'h54, 32'hA5A5_A5A5);
        fork
            i_cmb_node.send(1'b0, 11'h123, 64'h89AB_CDEF_0123_4567);
            wr(8'h94, 32'h0);
        join
        rd_chk("mb0 id", 8'h40, 32'h6123);
        rd_chk("mb0 lo", 8'h44, 32'h0123_4567);
        rd_chk("mb0 hi", 8'h48, 32'h89AB_CDEF);
        rd_chk("flags", 8'h08, 32'h1);
        i_cmb_node.send(1'b0, 11'h055, 64'h5);
        rd_chk("mb1 lo", 8'h54, 32'hA5A5_A5A5);
        rd_chk("flags", 8'h08, 32'h101);
        chk("pulses", pulses, 32'h1);
        wr(8'h08, 32'h1FF);
        rd_chk("flags", 8'h08, 32'h0);
        wr(8'h40, 32'h6123);
        $display("test receive done");
        wr(8'h70, 32'h42AA);
        wr(8'h74, 32'h1111_2222);
        wr(8'h78, 32'h3333_4444);
        wr(8'h80, 32'h111);
        i_cmb_node.slow = 3;
        i_cmb_node.send(1'b1, 11'h111, 64'h0);
        rd_chk("txreq", 8'h14, 32'h0);
        i_cmb_node.send(1'b1, 11'h2AA, 64'h0);
        for (int n = 0; n < 50 && i_cmb_node.tx_cnt == 0; n++) @(posedge clock);
        repeat (10) @(posedge clock);
        chk("tx count", i_cmb_node.tx_cnt, 32'h1);
        chk("tx id", {21'h0, i_cmb_node.got_id}, 32'h2AA);
        chk("tx lo", i_cmb_node.got_data[31:0], 32'h1111_2222);
        chk("tx hi", i_cmb_node.got_data[63:32], 32'h3333_4444);
        rd_chk("flags", 8'h08, 32'h8, 32'h8);
        chk("pulses", pulses, 32'h2);
        $display("test answer done");
        wr(8'h0C, 32'h0);
        i_cmb_node.errs(1'b1, 3);
        i_cmb_node.errs(1'b0, 15);
        rd_chk("err", 8'h0C, 32'h0003_0078);
        chk("passive", {31'h0, error_passive}, 32'h0);
        i_cmb_node.errs(1'b0, 1);
        rd_chk("err", 8'h0C, 32'h1003_0080);
        chk("passive", {31'h0, error_passive}, 32'h1);
        rd_chk("flags", 8'h08, 32'h40, 32'h40);
        i_cmb_node.errs(1'b0, 16);
        rd_chk("err", 8'h0C, 32'h2003_0100);
        chk("bus off", {31'h0, bus_off}, 32'h1);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        rd_chk("err", 8'h0C, 32'h0);
        chk("bus off", {31'h0, bus_off}, 32'h0);
        $display("test error state done");
        chk("rx stalls", i_cmb_node.stalls, 32'h0);
        end_of_test();
    end
endmodule
